// ===== dlwuc_pkg.sv
// constants and types for the dual log wiper update control block
// Overview of operation
// - one position option setting serves both channels at all times
// - option one gives 64 positions, 1dB per step, position 63 is mute
// - option two gives 34 positions: 12 steps 1dB, 12 steps 2dB, 8 steps 3dB
// - option two treats position 33 as mute and the last valid position
// - an acknowledged wiper command opens a 50ms window to apply the change
// - with zero-crossing on, a wiper moves when its terminals are equal
// - at window expiry without zero-crossing, the wiper moves anyway
// - with zero-crossing off, the wiper moves right after the acknowledge
// - both channels watch terminal equality and update independently
// - a user setting selects windowed or immediate wiper updates
// - low three slave address bits come from three address pins
// - the serial bus is ignored while chip enable is deasserted
// - command top bits: 00 channel 0, 01 channel 1, 10 config, 11 nothing
// - wiper commands carry the new position in the low six bits
// - config bit 1 enables zero-crossing, bit 0 picks the position option
// - only address bytes with upper nibble 0101 plus pin bits respond
package dlwuc_pkg;

  // slave address
  localparam logic [3:0] ADDR_PREFIX = 4'h5;

  // command byte targets, top two bits
  localparam logic [1:0] TGT_CH0 = 2'h0;
  localparam logic [1:0] TGT_CH1 = 2'h1;
  localparam logic [1:0] TGT_CFG = 2'h2;
  localparam int CMD_TGT_HI = 7;
  localparam int CMD_TGT_LO = 6;
  localparam int CMD_POS_HI = 5;

  // configuration fields and reset value
  localparam int CFG_OPT_BIT = 0;
  localparam int CFG_ZC_BIT = 1;
  localparam int CFG_PERS_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h87;

  // attenuation map
  localparam logic [5:0] MUTE_POS_OPT1 = 6'h3F;
  localparam logic [5:0] MUTE_POS_OPT2 = 6'h21;
  localparam logic [6:0] MUTE_DB = 7'h5A;
  localparam logic [5:0] SEG1_END = 6'h0C;
  localparam logic [5:0] SEG2_END = 6'h18;
  localparam logic [5:0] SEG3_END = 6'h20;
  localparam logic [6:0] SEG2_BASE_DB = 7'h0C;
  localparam logic [6:0] SEG3_BASE_DB = 7'h24;

  // serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // synchroniser reset: bus lines idle high, chip disabled
  localparam logic [5:0] SYNC_IDLE = 6'h23;
  localparam logic [2:0] ADDR_SYNC_RESET = 3'h0;

  // window timing
  localparam int WINDOW_MS = 50;
  localparam int CLK_HZ = 100_000_000;
  localparam int WINDOW_CYCLES = WINDOW_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 23;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_CMD = 3'b011,
    ST_ACK_CMD = 3'b100,
    ST_IGNORE = 3'b101
  } dlwuc_state_e;

endpackage : dlwuc_pkg

// ===== dlwuc_top.sv
// serial command decode, shared option setting and windowed wiper update timing
`timescale 1ns/10ps
module dlwuc_top #(
  parameter int WINDOW_CYCLES = dlwuc_pkg::WINDOW_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic chip_enable_n_in,
  // address select pins
  input wire logic addr_select_bit0_in,
  input wire logic addr_select_bit1_in,
  input wire logic addr_select_bit2_in,
  // terminal equality comparators, one per channel
  input wire logic zero_cross_ch0_in,
  input wire logic zero_cross_ch1_in,
  // wiper positions and attenuation
  output logic [5:0] wiper_terminal_ch0_out,
  output logic [5:0] wiper_terminal_ch1_out,
  output logic [6:0] atten_db_ch0_out,
  output logic [6:0] atten_db_ch1_out,
  // status and configuration
  output logic [1:0] update_pending_out,
  output logic zero_cross_enable_out,
  output logic position_option_select_out,
  output logic setting_persistence_select_out
);

  // attenuation in dB for a position under the shared option
  function automatic logic [6:0] atten_db(input logic [5:0] pos, input logic opt2);
    logic [6:0] p;
    p = {1'b0, pos};
    if (!opt2) begin
      atten_db = (pos == dlwuc_pkg::MUTE_POS_OPT1) ? dlwuc_pkg::MUTE_DB : p;
    end else if (pos <= dlwuc_pkg::SEG1_END) begin
      atten_db = p;
    end else if (pos <= dlwuc_pkg::SEG2_END) begin
      atten_db = 7'((p - {1'b0, dlwuc_pkg::SEG1_END}) * 2) + dlwuc_pkg::SEG2_BASE_DB;
    end else if (pos <= dlwuc_pkg::SEG3_END) begin
      atten_db = 7'((p - {1'b0, dlwuc_pkg::SEG2_END}) * 3) + dlwuc_pkg::SEG3_BASE_DB;
    end else begin
      atten_db = dlwuc_pkg::MUTE_DB;
    end
  endfunction : atten_db

  // two-flop synchronisers for every pin, plus one history stage for edges
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic scl_prev_q;
  logic sda_prev_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q <= dlwuc_pkg::SYNC_IDLE;
      sync2_q <= dlwuc_pkg::SYNC_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sync1_q <= {chip_enable_n_in, zero_cross_ch1_in, zero_cross_ch0_in, 1'b0, sda_in, scl_in};
      sync2_q <= sync1_q;
      scl_prev_q <= sync2_q[0];
      sda_prev_q <= sync2_q[1];
    end
  end

  // address straps are pins too, so they pass two flops before the compare
  logic [2:0] addr_sync1_q;
  logic [2:0] addr_sync2_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_sync1_q <= dlwuc_pkg::ADDR_SYNC_RESET;
      addr_sync2_q <= dlwuc_pkg::ADDR_SYNC_RESET;
    end else begin
      addr_sync1_q <= {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in};
      addr_sync2_q <= addr_sync1_q;
    end
  end

  // synchronised pin levels and bus events
  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire [1:0] zc_s = sync2_q[4:3];
  wire bus_on = ~sync2_q[5];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // serial slave registers
  dlwuc_pkg::dlwuc_state_e state_q;
  dlwuc_pkg::dlwuc_state_e state_d;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] cfg_q;

  // address match: fixed prefix, pin bits, write only
  wire [2:0] pin_addr = addr_sync2_q;
  wire addr_hit = (shift_q[7:4] == dlwuc_pkg::ADDR_PREFIX)
                & (shift_q[3:1] == pin_addr)
                & ~shift_q[0];
  wire byte_full = (bit_cnt_q == dlwuc_pkg::BITS_PER_BYTE);
  wire in_shift = (state_q == dlwuc_pkg::ST_ADDR) || (state_q == dlwuc_pkg::ST_CMD);
  // command accepted once the acknowledge clock falls
  wire cmd_done = bus_on & scl_fall & (state_q == dlwuc_pkg::ST_ACK_CMD);
  wire [1:0] cmd_tgt = shift_q[dlwuc_pkg::CMD_TGT_HI:dlwuc_pkg::CMD_TGT_LO];
  wire [5:0] cmd_pos = shift_q[dlwuc_pkg::CMD_POS_HI:0];
  wire zc_en = cfg_q[dlwuc_pkg::CFG_ZC_BIT];
  wire opt2 = cfg_q[dlwuc_pkg::CFG_OPT_BIT];

  // next state of the serial slave
  always_comb begin
    state_d = state_q;
    if (!bus_on || stop_ev) begin
      state_d = dlwuc_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_d = dlwuc_pkg::ST_ADDR;
    end else if (scl_fall) begin
      unique case (state_q)
        dlwuc_pkg::ST_ADDR: begin
          if (byte_full) begin
            state_d = addr_hit ? dlwuc_pkg::ST_ACK_ADDR : dlwuc_pkg::ST_IGNORE;
          end
        end
        dlwuc_pkg::ST_CMD: begin
          if (byte_full) begin
            state_d = dlwuc_pkg::ST_ACK_CMD;
          end
        end
        dlwuc_pkg::ST_ACK_ADDR: state_d = dlwuc_pkg::ST_CMD;
        dlwuc_pkg::ST_ACK_CMD: state_d = dlwuc_pkg::ST_CMD;
        dlwuc_pkg::ST_IDLE: state_d = dlwuc_pkg::ST_IDLE;
        dlwuc_pkg::ST_IGNORE: state_d = dlwuc_pkg::ST_IGNORE;
        default: state_d = dlwuc_pkg::ST_IDLE;
      endcase
    end
  end

  // slave state, bit count and shifter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= dlwuc_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (start_ev || (scl_fall && !in_shift)) begin
        bit_cnt_q <= 4'h0;
      end else if (scl_rise && in_shift && !byte_full) begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // shared configuration, one option for both channels
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q <= dlwuc_pkg::CFG_RESET;
    end else if (cmd_done && cmd_tgt == dlwuc_pkg::TGT_CFG) begin
      cfg_q <= shift_q;
    end
  end

  // per-channel load request, reserved target does nothing
  wire [1:0] load_req = {cmd_done & (cmd_tgt == dlwuc_pkg::TGT_CH1),
                         cmd_done & (cmd_tgt == dlwuc_pkg::TGT_CH0)};

  // per-channel wiper, pending target and window timer
  logic [5:0] wiper_q [2];
  logic [5:0] target_q [2];
  logic [1:0] pending_q;
  logic [dlwuc_pkg::TMR_W-1:0] timer_q [2];
  logic [6:0] atten_q [2];
  localparam logic [dlwuc_pkg::TMR_W-1:0] WIN_LAST = dlwuc_pkg::TMR_W'(WINDOW_CYCLES - 1);

  // channels run independently; a new command restarts that channel's window
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        wiper_q[i] <= dlwuc_pkg::MUTE_POS_OPT1;
        target_q[i] <= 6'h00;
        pending_q[i] <= 1'b0;
        timer_q[i] <= '0;
      end else if (load_req[i]) begin
        target_q[i] <= cmd_pos;
        timer_q[i] <= WIN_LAST;
        pending_q[i] <= zc_en;
        if (!zc_en) begin
          wiper_q[i] <= cmd_pos;
        end
      end else if (pending_q[i]) begin
        if (zc_s[i] || timer_q[i] == '0) begin
          wiper_q[i] <= target_q[i];
          pending_q[i] <= 1'b0;
        end else begin
          timer_q[i] <= timer_q[i] - 1'b1;
        end
      end
    end
  end

  // registered attenuation follows the wiper and the shared option
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        atten_q[i] <= dlwuc_pkg::MUTE_DB;
      end else begin
        atten_q[i] <= atten_db(wiper_q[i], opt2);
      end
    end
  end

  // open-drain data: only ever pulls low, during acknowledge slots
  assign sda_out = 1'b0;
  assign sda_oe_out = (state_q == dlwuc_pkg::ST_ACK_ADDR) || (state_q == dlwuc_pkg::ST_ACK_CMD);

  // outputs
  assign wiper_terminal_ch0_out = wiper_q[0];
  assign wiper_terminal_ch1_out = wiper_q[1];
  assign atten_db_ch0_out = atten_q[0];
  assign atten_db_ch1_out = atten_q[1];
  assign update_pending_out = pending_q;
  assign zero_cross_enable_out = zc_en;
  assign position_option_select_out = opt2;
  assign setting_persistence_select_out = cfg_q[dlwuc_pkg::CFG_PERS_BIT];

endmodule : dlwuc_top

// ===== dlwuc_top_sva.sv
// checker for attenuation map, wiper window timing and bus gating
`timescale 1ns/10ps
module dlwuc_sva #(
  parameter int WINDOW_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bus and comparator pins
  input wire logic scl_in,
  input wire logic chip_enable_n_in,
  input wire logic zero_cross_ch0_in,
  input wire logic sda_oe_out,
  // wipers and status
  input wire logic [5:0] wiper_terminal_ch0_out,
  input wire logic [5:0] wiper_terminal_ch1_out,
  input wire logic [6:0] atten_db_ch0_out,
  input wire logic [6:0] atten_db_ch1_out,
  input wire logic [1:0] update_pending_out,
  input wire logic zero_cross_enable_out,
  input wire logic position_option_select_out,
  input wire logic setting_persistence_select_out
);
  // a few cycles of sync latency beyond the window
  localparam int WMAX = WINDOW_CYCLES + 4;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // dB for a position under the shared option, positions past mute read as mute
  function automatic logic [6:0] db_of(input logic o, input logic [5:0] p);
    if (!o) return (p == 6'h3F) ? 7'h5A : {1'b0, p};
    if (p < 6'h0D) return {1'b0, p};
    if (p < 6'h19) return {p, 1'b0} - 7'h0C;
    if (p < 6'h21) return 7'(p) * 7'h03 - 7'h24;
    return 7'h5A;
  endfunction : db_of
  a_atten_map_ch0 : assert property (
    atten_db_ch0_out == db_of($past(position_option_select_out),
    $past(wiper_terminal_ch0_out))) else $error("ch0 attenuation off map");
  a_atten_map_ch1 : assert property (
    atten_db_ch1_out == db_of($past(position_option_select_out),
    $past(wiper_terminal_ch1_out))) else $error("ch1 attenuation off map");
  a_reset_values : assert property (disable iff (1'b0) rst_in |=>
    wiper_terminal_ch0_out == 6'h3F && wiper_terminal_ch1_out == 6'h3F
    && update_pending_out == 2'h0 && zero_cross_enable_out && position_option_select_out
    && setting_persistence_select_out) else $error("bad reset state");
  a_disabled_no_ack : assert property (
    chip_enable_n_in [*5] |-> !sda_oe_out) else $error("ack while disabled");
  a_ack_scl_low : assert property (
    $changed(sda_oe_out) |-> !scl_in) else $error("ack edge while clock high");
  a_window_bound_ch0 : assert property (
    $rose(update_pending_out[0]) |-> ##[1:WMAX] !update_pending_out[0])
    else $error("ch0 window overran");
  a_window_bound_ch1 : assert property (
    $rose(update_pending_out[1]) |-> ##[1:WMAX] !update_pending_out[1])
    else $error("ch1 window overran");
  a_zc_move_ch0 : assert property (
    update_pending_out[0] && zero_cross_ch0_in |-> ##[1:3] !update_pending_out[0])
    else $error("ch0 ignored zero crossing");
  a_zc_off_immediate : assert property (
    !zero_cross_enable_out [*8] |-> update_pending_out == 2'h0)
    else $error("pending with zero crossing off");
endmodule : dlwuc_sva
bind dlwuc_top dlwuc_sva #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_dlwuc_sva (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .chip_enable_n_in(chip_enable_n_in),
  .zero_cross_ch0_in(zero_cross_ch0_in), .sda_oe_out(sda_oe_out),
  .wiper_terminal_ch0_out(wiper_terminal_ch0_out),
  .wiper_terminal_ch1_out(wiper_terminal_ch1_out),
  .atten_db_ch0_out(atten_db_ch0_out), .atten_db_ch1_out(atten_db_ch1_out),
  .update_pending_out(update_pending_out), .zero_cross_enable_out(zero_cross_enable_out),
  .position_option_select_out(position_option_select_out),
  .setting_persistence_select_out(setting_persistence_select_out));

// ===== dlwuc_i2c_mst.sv
// bus master model: drives clock and data, reads the device acknowledge
`timescale 1ns/10ps
module dlwuc_i2c_mst #(
  parameter int HALF = 10
) (
  // clock
  input wire logic clk_in,
  // device pull-down
  input wire logic sda_oe_in,
  // bus lines
  output logic scl_out,
  output logic sda_out
);
  logic pull_low = 1'b0;
  initial scl_out = 1'b1;
  // wired-and with pull-up, so a released line reads high
  assign sda_out = !(pull_low || sda_oe_in);
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // eight bits msb first then the ack bit; data moves two cycles after clock low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      pull_low = (i > 0) ? !b[i - 1] : 1'b0;
      tick(HALF);
      scl_out = 1'b1;
      ack = !sda_out;
      tick(HALF);
      scl_out = 1'b0;
      tick(2);
    end
  endtask : send
  // start, address, two command bytes, stop; ack high only if every byte acked
  task automatic xfer(input logic [7:0] a, c, d, output logic ack);
    logic k0, k1, k2;
    tick(HALF);
    pull_low = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(2);
    send(a, k0);
    send(c, k1);
    send(d, k2);
    pull_low = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    pull_low = 1'b0;
    ack = k0 & k1 & k2;
  endtask : xfer
endmodule : dlwuc_i2c_mst

// ===== tb_top.sv
// self-checking bench: option maps, command decode, window timing, bus gating
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module tb_top;
  localparam int WIN = 200;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_n = 1'b0;
  logic zc0 = 1'b0;
  logic zc1 = 1'b0;
  logic [2:0] pins = 3'h5;
  logic scl, sda, oe, ack, zc_en, opt, pers;
  logic [5:0] w0, w1;
  logic [6:0] a0, a1;
  logic [1:0] pend;
  int n_errors = 0;
  int checked = 0;
  // cfg, command, target position, target dB, other channel dB
  logic [39:0] rows [10] = '{40'h80_05_05_05_5A, 40'h80_7E_3E_3E_05, 40'h80_3F_3F_5A_3E,
    40'h81_0C_0C_0C_5A, 40'h81_4D_0D_0E_0C, 40'h81_18_18_24_0E, 40'h81_59_19_27_24,
    40'h81_20_20_3C_27, 40'h81_61_21_5A_3C, 40'h81_C5_21_5A_3C};
  logic [7:0] bad [4] = '{8'h58, 8'h6A, 8'h5B, 8'h5A};
  always #5 clk_in = ~clk_in;
  dlwuc_top #(.WINDOW_CYCLES(WIN)) u_dlwuc_top (.clk_in(clk_in), .rst_in(rst_in),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(oe), .chip_enable_n_in(ce_n),
    .addr_select_bit0_in(pins[0]), .addr_select_bit1_in(pins[1]),
    .addr_select_bit2_in(pins[2]), .zero_cross_ch0_in(zc0), .zero_cross_ch1_in(zc1),
    .wiper_terminal_ch0_out(w0), .wiper_terminal_ch1_out(w1), .atten_db_ch0_out(a0),
    .atten_db_ch1_out(a1), .update_pending_out(pend), .zero_cross_enable_out(zc_en),
    .position_option_select_out(opt), .setting_persistence_select_out(pers));
  dlwuc_i2c_mst u_dlwuc_i2c_mst (.clk_in(clk_in), .sda_oe_in(oe), .scl_out(scl),
    .sda_out(sda));
  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // watchdog sized well past the expected run of about 11300 cycles
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(negedge clk_in);
    `CHK({w0, w1, a0, a1}, {6'h3F, 6'h3F, 7'h5A, 7'h5A})
    rst_in = 1'b0;
    `CHK({pend, zc_en, opt, pers}, 5'h07)
    // option maps with zero crossing off, so each change lands at once
    for (int i = 0; i < 10; i++) begin
      u_dlwuc_i2c_mst.xfer(8'h5A, rows[i][39:32], rows[i][31:24], ack);
      `CHK(ack, 1'b1)
      `CHK({pers, zc_en, opt}, rows[i][34:32])
      `CHK(rows[i][30] ? w1 : w0, rows[i][21:16])
      `CHK(rows[i][30] ? a1 : a0, rows[i][14:8])
      `CHK(rows[i][30] ? a0 : a1, rows[i][6:0])
    end
    // pin mismatch, wrong prefix, read, then a matching address while disabled
    for (int k = 0; k < 4; k++) begin
      ce_n = (k == 3);
      u_dlwuc_i2c_mst.xfer(bad[k], 8'h83, 8'h01, ack);
      `CHK({ack, w0, zc_en}, {1'b0, 6'h20, 1'b0})
    end
    ce_n = 1'b0;
    // zero crossing on: other channel's event must not release channel 0
    u_dlwuc_i2c_mst.xfer(8'h5A, 8'h83, 8'h07, ack);
    `CHK({pend, w0}, {2'h1, 6'h20})
    zc1 = 1'b1;
    repeat (10) @(negedge clk_in);
    `CHK({pend, w0, w1}, {2'h1, 6'h20, 6'h21})
    zc0 = 1'b1;
    repeat (6) @(negedge clk_in);
    `CHK({pend, w0}, {2'h0, 6'h07})
    zc0 = 1'b0;
    zc1 = 1'b0;
    // no crossing at all: the window running out moves the wiper
    u_dlwuc_i2c_mst.xfer(8'h5A, 8'h83, 8'h49, ack);
    `CHK({pend, w1}, {2'h2, 6'h21})
    repeat (WIN) @(negedge clk_in);
    `CHK({pend, w1}, {2'h0, 6'h09})
    // reset in mid-window drops the pending move and restores defaults
    u_dlwuc_i2c_mst.xfer(8'h5A, 8'h83, 8'h11, ack);
    `CHK({ack, pend}, {1'b1, 2'h1})
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK({pend, w0, w1, zc_en, opt, pers}, {2'h0, 6'h3F, 6'h3F, 3'h7})
    rst_in = 1'b0;
    repeat (WIN + 10) @(negedge clk_in);
    `CHK({pend, w0}, {2'h0, 6'h3F})
    end_sim();
  end
endmodule : tb_top
